/* core/vws_cmd.sv */
`timescale 1ns/1ps
module vws_cmd #(
  parameter int SPT        = vws_pkg::SPT_DEFAULT,
  parameter int HEADS      = vws_pkg::HEADS_DEF,
  parameter int SECT_WORDS = vws_pkg::SECT_WORDS,
  parameter int FIFO_DEPTH = vws_pkg::FIFO_DEPTH
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [9:0]  HOST_ADDR,
  input  wire logic        HOST_WR,
  input  wire logic        HOST_RD,
  input  wire logic [7:0]  HOST_WDATA,
  output logic      [7:0]  HOST_RDATA,
  output logic             HOST_INTRQ,
  input  wire logic        HOST_DVALID,
  input  wire logic [15:0] HOST_DATA,
  output logic             HOST_DREADY,
  output logic             MED_SEEK,
  output logic      [19:0] MED_TRACK,
  input  wire logic        MED_SEEK_DONE,
  output logic             MED_VERIFY,
  output logic             MED_WRITE,
  output logic             MED_LBA_MODE,
  output logic      [31:0] MED_ADDR,
  output logic      [15:0] MED_WDATA,
  output logic             MED_WVALID,
  input  wire logic        MED_WREADY,
  input  wire logic        MED_SECT_DONE,
  input  wire logic        MED_SECT_ERR
);

  localparam int WCW = $clog2(SECT_WORDS);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] next_address(input logic [31:0] a);
    logic [27:0] lba;
    logic [7:0]  dh;
    logic [15:0] cyl;
    logic [3:0]  hd;
    logic [7:0]  sn;
    lba = a[27:0];
    dh  = a[31:24];
    cyl = a[23:8];
    hd  = dh[3:0];
    sn  = a[7:0];
    if (dh[vws_pkg::DH_LBA])
    begin
      lba = lba + 28'h1;
      next_address = {dh[7:4], lba};
    end
    else
    begin
      if (sn >= 8'(SPT))
      begin
        sn = 8'h01;
        if (hd == 4'(HEADS - 1))
        begin
          hd  = 4'h0;
          cyl = cyl + 16'h1;
        end
        else
          hd = hd + 4'h1;
      end
      else
        sn = sn + 8'h01;
      next_address = {dh[7:4], hd, cyl, sn};
    end
  endfunction : next_address

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--)
      r = (r[15] ^ d[i]) ? ((r << 1) ^ vws_pkg::CRC_POLY) : (r << 1);
    crc_step = r;
  endfunction : crc_step

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  vws_pkg::vws_state_e state;
  logic [7:0]          sector_count;
  logic [7:0]          sector_number;
  logic [7:0]          cylinder_low;
  logic [7:0]          cylinder_high;
  logic [7:0]          device_head_select;
  logic [7:0]          error_info;
  logic                err_flag;
  logic [8:0]          remain;
  logic                is_write;
  logic [19:0]         cur_track;
  logic                track_known;
  logic [WCW-1:0]      word_cnt;
  logic [15:0]         crc;
  logic [15:0]         ecc;
  logic                busy;

  logic                cmd_take;
  logic                cmd_verify;
  logic                cmd_write;
  logic [19:0]         target_track;
  logic                sect_ok;
  logic                sect_bad;
  logic                last_sect;
  logic                fifo_out_valid;
  logic [15:0]         fifo_out_data;
  logic                fifo_out_ready;
  logic                fifo_in_ready;
  logic                word_take;

  assign busy       = (state != vws_pkg::VWS_IDLE);
  assign cmd_take   = HOST_WR & ~busy
                    & (HOST_ADDR == vws_pkg::OFS_COMMAND_CODE);
  assign cmd_verify = (HOST_WDATA[7:1] == vws_pkg::CMD_VERIFY[7:1]);
  assign cmd_write  = (HOST_WDATA[7:1] == vws_pkg::CMD_WRITE[7:1]);
  assign target_track = {device_head_select[3:0], cylinder_high,
                         cylinder_low};
  assign sect_ok    = (state == vws_pkg::VWS_WAIT) & MED_SECT_DONE
                    & ~MED_SECT_ERR;
  assign sect_bad   = (state == vws_pkg::VWS_WAIT) & MED_SECT_DONE
                    & MED_SECT_ERR;
  assign last_sect  = (remain == 9'd1);
  assign word_take  = (state == vws_pkg::VWS_DATA) & fifo_out_valid
                    & MED_WREADY;

  // ----------------------------------------------------------------------
  // write data buffer
  // ----------------------------------------------------------------------
  // host data is only taken while a write command runs, so a stalled
  // media stream backs up through the buffer to the host
  assign HOST_DREADY    = busy & is_write & fifo_in_ready;
  assign fifo_out_ready = word_take;

  vws_fifo #(
    .WIDTH (vws_pkg::DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst       (RST),
    .flush     (cmd_take),
    .in_valid  (HOST_DVALID & busy & is_write),
    .in_ready  (fifo_in_ready),
    .in_data   (HOST_DATA),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------------
  // media stream: data words, then check words
  // ----------------------------------------------------------------------
  always_comb
  begin
    MED_WVALID = 1'b0;
    MED_WDATA  = fifo_out_data;
    case (state)
      vws_pkg::VWS_DATA:
        MED_WVALID = fifo_out_valid;
      vws_pkg::VWS_CRC:
      begin
        MED_WVALID = 1'b1;
        MED_WDATA  = crc;
      end
      vws_pkg::VWS_ECC:
      begin
        MED_WVALID = 1'b1;
        MED_WDATA  = ecc;
      end
      default:
        MED_WVALID = 1'b0;
    endcase
  end

  assign MED_TRACK    = target_track;
  assign MED_LBA_MODE = device_head_select[vws_pkg::DH_LBA];
  assign MED_ADDR     = {device_head_select, cylinder_high, cylinder_low,
                         sector_number};

  // ----------------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      state       <= vws_pkg::VWS_IDLE;
      is_write    <= 1'b0;
      MED_SEEK    <= 1'b0;
      MED_VERIFY  <= 1'b0;
      MED_WRITE   <= 1'b0;
      cur_track   <= '0;
      track_known <= 1'b0;
      word_cnt    <= '0;
    end
    else
    begin
      MED_SEEK   <= 1'b0;
      MED_VERIFY <= 1'b0;
      MED_WRITE  <= 1'b0;
      case (state)
        vws_pkg::VWS_IDLE:
          if (cmd_take & (cmd_verify | cmd_write))
          begin
            is_write <= cmd_write;
            state    <= vws_pkg::VWS_POS;
          end
        vws_pkg::VWS_POS:
          if (track_known & (cur_track == target_track))
            state <= vws_pkg::VWS_GO;
          else
          begin
            MED_SEEK <= 1'b1;
            state    <= vws_pkg::VWS_SEEKW;
          end
        vws_pkg::VWS_SEEKW:
          if (MED_SEEK_DONE)
          begin
            cur_track   <= target_track;
            track_known <= 1'b1;
            state       <= vws_pkg::VWS_GO;
          end
        vws_pkg::VWS_GO:
        begin
          word_cnt <= '0;
          if (is_write)
          begin
            MED_WRITE <= 1'b1;
            state     <= vws_pkg::VWS_DATA;
          end
          else
          begin
            // no transfer phase: the check stays inside the drive
            MED_VERIFY <= 1'b1;
            state      <= vws_pkg::VWS_WAIT;
          end
        end
        vws_pkg::VWS_DATA:
          if (word_take)
          begin
            word_cnt <= word_cnt + 1'b1;
            if (word_cnt == WCW'(SECT_WORDS - 1))
              state <= vws_pkg::VWS_CRC;
          end
        vws_pkg::VWS_CRC:
          if (MED_WREADY)
            state <= vws_pkg::VWS_ECC;
        vws_pkg::VWS_ECC:
          if (MED_WREADY)
            state <= vws_pkg::VWS_WAIT;
        vws_pkg::VWS_WAIT:
          if (sect_bad | (sect_ok & last_sect))
            state <= vws_pkg::VWS_IDLE;
          else if (sect_ok)
            state <= vws_pkg::VWS_POS;
        default:
          state <= vws_pkg::VWS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // check words
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      crc <= vws_pkg::CRC_INIT;
      ecc <= '0;
    end
    else if (state == vws_pkg::VWS_GO)
    begin
      crc <= vws_pkg::CRC_INIT;
      ecc <= '0;
    end
    else if (word_take)
    begin
      crc <= crc_step(crc, fifo_out_data);
      ecc <= {ecc[14:0], ecc[15]} ^ fifo_out_data;
    end
  end

  // ----------------------------------------------------------------------
  // task-file registers
  // ----------------------------------------------------------------------
  // host writes are ignored while busy so the engine owns the address
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      sector_count       <= vws_pkg::RST_SECTOR_COUNT;
      sector_number      <= vws_pkg::RST_SECTOR_NUMBER;
      cylinder_low       <= vws_pkg::RST_CYLINDER;
      cylinder_high      <= vws_pkg::RST_CYLINDER;
      device_head_select <= vws_pkg::RST_DEVICE_HEAD;
      remain             <= '0;
    end
    else if (HOST_WR & ~busy)
    begin
      case (HOST_ADDR)
        vws_pkg::OFS_SECTOR_COUNT:  sector_count       <= HOST_WDATA;
        vws_pkg::OFS_SECTOR_NUMBER: sector_number      <= HOST_WDATA;
        vws_pkg::OFS_CYLINDER_LOW:  cylinder_low       <= HOST_WDATA;
        vws_pkg::OFS_CYLINDER_HIGH: cylinder_high      <= HOST_WDATA;
        vws_pkg::OFS_DEVICE_HEAD:   device_head_select <= HOST_WDATA;
        vws_pkg::OFS_COMMAND_CODE:
          remain <= (sector_count == 8'h00) ? 9'(vws_pkg::MAX_SECTORS)
                                            : {1'b0, sector_count};
        default:
          remain <= remain;
      endcase
    end
    else if (sect_ok)
    begin
      remain       <= remain - 9'd1;
      sector_count <= 8'(remain - 9'd1);
      if (!last_sect)
        {device_head_select, cylinder_high, cylinder_low, sector_number}
          <= next_address(MED_ADDR);
      // last sector keeps its address
    end
    else if (sect_bad)
      // failing address stays in place, count keeps it
      sector_count <= remain[7:0];
  end

  // ----------------------------------------------------------------------
  // status, error and interrupt
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      error_info <= vws_pkg::RST_ERROR_INFO;
      err_flag   <= 1'b0;
      HOST_INTRQ <= 1'b0;
    end
    else
    begin
      if (cmd_take)
      begin
        error_info <= '0;
        err_flag   <= ~(cmd_verify | cmd_write);
        error_info[vws_pkg::ER_ABRT] <= ~(cmd_verify | cmd_write);
        HOST_INTRQ <= ~(cmd_verify | cmd_write);
      end
      else if (sect_bad)
      begin
        err_flag <= 1'b1;
        if (is_write)
          error_info[vws_pkg::ER_IDNF] <= 1'b1;
        else
          error_info[vws_pkg::ER_UNC] <= 1'b1;
        HOST_INTRQ <= 1'b1;
      end
      else if (sect_ok & last_sect)
        HOST_INTRQ <= 1'b1;
      else if (HOST_RD & (HOST_ADDR == vws_pkg::OFS_DRIVE_STATUS))
        HOST_INTRQ <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      HOST_RDATA <= '0;
    else if (HOST_RD)
    begin
      case (HOST_ADDR)
        vws_pkg::OFS_ERROR_INFO:    HOST_RDATA <= error_info;
        vws_pkg::OFS_SECTOR_COUNT:  HOST_RDATA <= sector_count;
        vws_pkg::OFS_SECTOR_NUMBER: HOST_RDATA <= sector_number;
        vws_pkg::OFS_CYLINDER_LOW:  HOST_RDATA <= cylinder_low;
        vws_pkg::OFS_CYLINDER_HIGH: HOST_RDATA <= cylinder_high;
        vws_pkg::OFS_DEVICE_HEAD:   HOST_RDATA <= device_head_select;
        vws_pkg::OFS_DRIVE_STATUS:
        begin
          HOST_RDATA                   <= '0;
          HOST_RDATA[vws_pkg::ST_BUSY] <= busy;
          HOST_RDATA[vws_pkg::ST_READY] <= ~busy;
          HOST_RDATA[vws_pkg::ST_DRQ]  <= HOST_DREADY;
          HOST_RDATA[vws_pkg::ST_ERR]  <= err_flag;
        end
        default:
          HOST_RDATA <= '0;
      endcase
    end
  end

endmodule : vws_cmd

/* core/vws_fifo.sv */
`timescale 1ns/1ps
module vws_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_idx];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_idx] <= in_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end
    else if (flush)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + 1'b1;
      if (pop)
        rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : vws_fifo

/* inc/vws_pkg.sv */
package vws_pkg;

  // ----------------------------------------------------------------------
  // task-file register offsets
  // ----------------------------------------------------------------------
  localparam logic [9:0] OFS_FEATURE_SELECT = 10'h1f1;
  localparam logic [9:0] OFS_ERROR_INFO     = 10'h1f1;
  localparam logic [9:0] OFS_SECTOR_COUNT   = 10'h1f2;
  localparam logic [9:0] OFS_SECTOR_NUMBER  = 10'h1f3;
  localparam logic [9:0] OFS_CYLINDER_LOW   = 10'h1f4;
  localparam logic [9:0] OFS_CYLINDER_HIGH  = 10'h1f5;
  localparam logic [9:0] OFS_DEVICE_HEAD    = 10'h1f6;
  localparam logic [9:0] OFS_COMMAND_CODE   = 10'h1f7;
  localparam logic [9:0] OFS_DRIVE_STATUS   = 10'h1f7;

  // ----------------------------------------------------------------------
  // command codes (bit 0 is ignored when decoding)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_VERIFY = 8'h40;
  localparam logic [7:0] CMD_WRITE  = 8'h30;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int ST_BUSY  = 7;
  localparam int ST_READY = 6;
  localparam int ST_DRQ   = 3;
  localparam int ST_ERR   = 0;
  localparam int ER_UNC   = 6;
  localparam int ER_IDNF  = 4;
  localparam int ER_ABRT  = 2;
  localparam int DH_LBA   = 6;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_SECTOR_COUNT  = 8'h01;
  localparam logic [7:0] RST_SECTOR_NUMBER = 8'h01;
  localparam logic [7:0] RST_CYLINDER      = 8'h00;
  localparam logic [7:0] RST_DEVICE_HEAD   = 8'ha0;
  localparam logic [7:0] RST_ERROR_INFO    = 8'h00;

  // ----------------------------------------------------------------------
  // sizes and check codes
  // ----------------------------------------------------------------------
  localparam int          MAX_SECTORS = 256;
  localparam int          SECT_WORDS  = 256;
  localparam int          FIFO_DEPTH  = 16;
  localparam int          DATA_W      = 16;
  localparam int          SPT_DEFAULT = 63;
  localparam int          HEADS_DEF   = 16;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRC_INIT    = 16'hffff;

  typedef enum logic [2:0] {
    VWS_IDLE, VWS_POS, VWS_SEEKW, VWS_GO, VWS_DATA, VWS_CRC, VWS_ECC,
    VWS_WAIT
  } vws_state_e;

endpackage : vws_pkg

/* test/verify_and_write_sector_commands_tb.sv */
`timescale 1ns/1ps
module verify_and_write_sector_commands_tb;
  localparam int NW = 4;
  logic        clk, rst, wr, rd, dvalid, intrq, dready, seek, sdone;
  logic        mver, mwr, lba, wvalid, wready, sect_done, sect_err, err_en;
  logic [9:0]  addr;
  logic [7:0]  wdata, rdata, err_sect, s;
  logic [15:0] hdata, mwdata;
  logic [19:0] track;
  logic [31:0] maddr;
  int          fail_count, total_checks;
  localparam logic [9:0] a_cnt = vws_pkg::OFS_SECTOR_COUNT;
  localparam logic [9:0] a_sec = vws_pkg::OFS_SECTOR_NUMBER;
  localparam logic [9:0] a_sta = vws_pkg::OFS_DRIVE_STATUS;

  vws_cmd #(.SECT_WORDS(NW)) i_vws_cmd (.SYS_CLK(clk), .RST(rst),
    .HOST_ADDR(addr), .HOST_WR(wr), .HOST_RD(rd), .HOST_WDATA(wdata),
    .HOST_RDATA(rdata), .HOST_INTRQ(intrq), .HOST_DVALID(dvalid),
    .HOST_DATA(hdata), .HOST_DREADY(dready), .MED_SEEK(seek),
    .MED_TRACK(track), .MED_SEEK_DONE(sdone), .MED_VERIFY(mver),
    .MED_WRITE(mwr), .MED_LBA_MODE(lba), .MED_ADDR(maddr),
    .MED_WDATA(mwdata), .MED_WVALID(wvalid), .MED_WREADY(wready),
    .MED_SECT_DONE(sect_done), .MED_SECT_ERR(sect_err));
  vws_media #(.SECT_WORDS(NW)) i_vws_media (.clk(clk), .rst(rst),
    .seek(seek), .seek_done(sdone), .verify(mver), .write(mwr),
    .addr(maddr), .wdata(mwdata), .wvalid(wvalid), .wready(wready),
    .done(sect_done), .err(sect_err), .err_en(err_en),
    .err_sect(err_sect));

  task automatic end_sim();
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // ----------------------------------------------------------------
  // host register cycles, one-cycle strobes
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg
  task automatic issue(input logic [7:0] hd, cyh, cyl, sec, cnt, cmd);
    wr_reg(vws_pkg::OFS_DEVICE_HEAD, hd);
    wr_reg(vws_pkg::OFS_CYLINDER_HIGH, cyh);
    wr_reg(vws_pkg::OFS_CYLINDER_LOW, cyl);
    wr_reg(a_sec, sec);
    wr_reg(a_cnt, cnt);
    i_vws_media.words.delete();
    wr_reg(vws_pkg::OFS_COMMAND_CODE, cmd);
  endtask : issue
  task automatic wait_irq();
    int n;
    n = 0;
    while (intrq !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 4000)
    begin
      fail_count++;
      end_sim();
    end
  endtask : wait_irq
  // handshake judged on the pre-edge value of dready
  task automatic send(input int n, input logic [15:0] b);
    int i, t;
    i = 0;
    t = 0;
    @(posedge clk);
    dvalid <= 1'b1;
    hdata <= b;
    while (i < n && t < 4000)
    begin
      @(posedge clk);
      t++;
      if (dready === 1'b1)
      begin
        i++;
        hdata <= b + 16'(i);
      end
    end
    dvalid <= 1'b0;
    chk(i, n);
    if (i != n)
      end_sim();
  endtask : send
  task automatic fin(input logic [7:0] e_sec, e_cnt, e_err);
    rd_reg(a_sta, s);
    chk(s[vws_pkg::ST_BUSY], 0);
    chk(s[vws_pkg::ST_ERR], e_err != 0);
    chk(intrq, 0);
    rd_reg(vws_pkg::OFS_ERROR_INFO, s);
    chk(s, e_err);
    rd_reg(a_sec, s);
    chk(s, e_sec);
    rd_reg(a_cnt, s);
    chk(s, e_cnt);
  endtask : fin
  function automatic logic [15:0] crc(input logic [15:0] b);
    logic [15:0] c, w;
    c = vws_pkg::CRC_INIT;
    for (int i = 0; i < NW; i++)
    begin
      w = b + 16'(i);
      for (int k = 15; k >= 0; k--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ w[k]) ? vws_pkg::CRC_POLY : 16'h0);
    end
    return c;
  endfunction : crc
  function automatic logic [15:0] ecc(input logic [15:0] b);
    logic [15:0] e;
    e = '0;
    for (int i = 0; i < NW; i++)
      e = {e[14:0], e[15]} ^ (b + 16'(i));
    return e;
  endfunction : ecc
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [9:0] a[7] = '{10'h1f1, 10'h1f2, 10'h1f3, 10'h1f4, 10'h1f5,
                         10'h1f6, 10'h1f0};
    logic [7:0] v[7] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'ha0, 8'h00};
    for (int i = 0; i < 7; i++)
    begin
      rd_reg(a[i], s);
      chk(s, v[i]);
    end
    rd_reg(a_sta, s);
    chk(s, 8'h1 << vws_pkg::ST_READY);
  endtask : t_reset
  task automatic t_verify(input logic [7:0] cmd, input logic bad);
    err_en <= bad;
    err_sect <= 8'h06;
    issue(8'ha2, 8'h00, 8'h12, 8'h05, 8'h03, cmd);
    wait_irq();
    chk(i_vws_media.words.size(), 0);
    if (bad)
      fin(8'h06, 8'h02, 8'h1 << vws_pkg::ER_UNC);
    else
      fin(8'h07, 8'h00, 8'h00);
  endtask : t_verify
  task automatic t_write(input logic [7:0] hd, sec, cnt, cmd,
                         input logic bad);
    int k;
    err_en <= bad;
    err_sect <= sec + 8'h01;
    issue(hd, 8'h00, 8'h00, sec, cnt, cmd);
    send(2 * NW, 16'h1000);
    wait_irq();
    chk(lba, hd[vws_pkg::DH_LBA]);
    chk(i_vws_media.words.size(), 2 * (NW + 2));
    for (int j = 0; j < 2; j++)
    begin
      k = j * (NW + 2);
      for (int i = 0; i < NW; i++)
        chk(i_vws_media.words[k + i], 16'h1000 + j * NW + i);
      chk(i_vws_media.words[k + NW], crc(16'h1000 + j * NW));
      chk(i_vws_media.words[k + NW + 1], ecc(16'h1000 + j * NW));
    end
    fin(sec + 8'h01, bad ? 8'hff : 8'h00,
        8'(bad) << vws_pkg::ER_IDNF);
  endtask : t_write

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    {rst, wr, rd, dvalid, err_en} = 5'h10;
    {addr, wdata, hdata, err_sect} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_verify(8'h41, 1'b0);
    t_verify(8'h40, 1'b1);
    t_write(8'ha3, 8'h0a, 8'h02, 8'h30, 1'b0);
    t_write(8'he0, 8'h20, 8'h00, 8'h31, 1'b1);
    end_sim();
  end
endmodule : verify_and_write_sector_commands_tb

/* test/vws_cmd_asserts.sv */
`timescale 1ns/1ps
module vws_cmd_asserts #(
  parameter int SECT_WORDS = 256
) (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic [9:0]  HOST_ADDR,
  input wire logic        HOST_RD,
  input wire logic        HOST_INTRQ,
  input wire logic        MED_SEEK,
  input wire logic [19:0] MED_TRACK,
  input wire logic        MED_SEEK_DONE,
  input wire logic        MED_VERIFY,
  input wire logic        MED_WRITE,
  input wire logic [31:0] MED_ADDR,
  input wire logic        MED_WVALID,
  input wire logic        MED_WREADY,
  input wire logic        MED_SECT_DONE,
  input wire logic        MED_SECT_ERR
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic seek_pend;
  logic v_act;
  logic w_act;
  int   wcnt;
  // ----------------------------------------------------------------
  // helper state: what the media side is busy with
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST)
    if (RST) seek_pend <= 1'b0;
    else if (MED_SEEK) seek_pend <= 1'b1;
    else if (MED_SEEK_DONE) seek_pend <= 1'b0;
  always_ff @(posedge SYS_CLK or posedge RST)
    if (RST) v_act <= 1'b0;
    else if (MED_VERIFY) v_act <= 1'b1;
    else if (MED_SECT_DONE) v_act <= 1'b0;
  always_ff @(posedge SYS_CLK or posedge RST)
    if (RST)
    begin
      w_act <= 1'b0;
      wcnt  <= 0;
    end
    else if (MED_WRITE)
    begin
      w_act <= 1'b1;
      wcnt  <= 0;
    end
    else if (MED_SECT_DONE) w_act <= 1'b0;
    else if (MED_WVALID && MED_WREADY) wcnt <= wcnt + 1;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_seek_gate: assert property (
    (MED_WRITE || MED_VERIFY) |-> !seek_pend)
    else $error("sector started before seek finished");
  a_verify_silent: assert property (v_act |-> !MED_WVALID)
    else $error("data streamed during verify");
  a_sector_words: assert property (
    MED_SECT_DONE && w_act |-> wcnt == SECT_WORDS + 2)
    else $error("sector word count wrong");
  // the target track must not move while the head is travelling to it
  a_track_hold: assert property (
    seek_pend |-> $stable(MED_TRACK))
    else $error("seek track changed during seek");
  a_err_intrq: assert property (
    MED_SECT_DONE && MED_SECT_ERR |=> HOST_INTRQ)
    else $error("no interrupt after error");
  a_err_stops: assert property (
    MED_SECT_DONE && MED_SECT_ERR |=> (!MED_WRITE && !MED_VERIFY)[*8])
    else $error("sector started after error");
  a_intrq_cause: assert property (
    $rose(HOST_INTRQ) |-> $past(MED_SECT_DONE))
    else $error("interrupt without sector end");
  // a failing or last sector end in the same cycle sets the interrupt again: set wins
  a_intrq_clear: assert property (
    HOST_RD && HOST_ADDR == vws_pkg::OFS_DRIVE_STATUS && !MED_SECT_DONE
    |=> !HOST_INTRQ)
    else $error("status read left interrupt set");
  c_seek: cover property (MED_SEEK);
  c_err: cover property (MED_SECT_DONE && MED_SECT_ERR);
  c_irq: cover property ($rose(HOST_INTRQ));
endmodule : vws_cmd_asserts

bind vws_cmd vws_cmd_asserts #(.SECT_WORDS(SECT_WORDS)) i_vws_cmd_asserts (
  .SYS_CLK(SYS_CLK), .RST(RST), .HOST_ADDR(HOST_ADDR), .HOST_RD(HOST_RD),
  .HOST_INTRQ(HOST_INTRQ), .MED_SEEK(MED_SEEK), .MED_TRACK(MED_TRACK),
  .MED_SEEK_DONE(MED_SEEK_DONE), .MED_VERIFY(MED_VERIFY),
  .MED_WRITE(MED_WRITE), .MED_ADDR(MED_ADDR), .MED_WVALID(MED_WVALID),
  .MED_WREADY(MED_WREADY), .MED_SECT_DONE(MED_SECT_DONE),
  .MED_SECT_ERR(MED_SECT_ERR));

/* test/vws_media.sv */
`timescale 1ns/1ps
module vws_media #(
  parameter int SECT_WORDS = 4
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        seek,
  output logic             seek_done,
  input  wire logic        verify,
  input  wire logic        write,
  input  wire logic [31:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wvalid,
  output logic             wready,
  output logic             done,
  output logic             err,
  input  wire logic        err_en,
  input  wire logic [7:0]  err_sect
);
  logic [15:0] words[$];
  int          sdly, vdly, wcnt;
  logic        wact, tog;
  logic [7:0]  sect;
  // stalls every other cycle so the buffer has to hold words back
  assign wready = wact && tog && wcnt < SECT_WORDS + 2;
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      {seek_done, done, err, wact, tog} <= 5'h00;
      {sdly, vdly, wcnt} <= '0;
    end
    else
    begin
      seek_done <= 1'b0;
      done <= 1'b0;
      err <= ~err; // error flag means nothing outside done
      tog <= ~tog;
      if (seek) sdly <= 5;
      else if (sdly == 1) seek_done <= 1'b1;
      if (sdly != 0 && !seek) sdly <= sdly - 1;
      if (verify)
      begin
        vdly <= 3;
        sect <= addr[7:0];
      end
      else if (vdly != 0)
      begin
        vdly <= vdly - 1;
        done <= vdly == 1;
        if (vdly == 1) err <= err_en && sect == err_sect;
      end
      if (write)
      begin
        wact <= 1'b1;
        wcnt <= 0;
        sect <= addr[7:0];
      end
      else if (wact && wcnt == SECT_WORDS + 2)
      begin
        wact <= 1'b0;
        done <= 1'b1;
        err <= err_en && sect == err_sect;
      end
      if (wvalid && wready)
      begin
        words.push_back(wdata);
        wcnt <= wcnt + 1;
      end
    end
endmodule : vws_media
